// ==== cee_pkg.sv ====
//
// Operation
// RULE_01: Reset outranks every trap and interrupt pending at the same time.
// RULE_02: Reset handling starts once the chip init pin is released, not while held.
// RULE_03: Watchdog overflow resets the chip and starts handling identical to pin reset.
// RULE_04: Software vector call starts handling at a vector chosen by its 2-bit selector.
// RULE_05: Software vector call is taken regardless of the interrupt mask bit.
// RULE_06: Mask bit at 1 blocks all interrupts except unmaskable pin and address break.
// RULE_07: Accepted interrupts enter only when the current instruction or handling completes.
// RULE_08: Several pending interrupts are serviced in fixed priority order, highest first.
// RULE_09: Unmaskable pin detects falling edge when polarity is 0, rising when 1.
// RULE_10: A masked request stays pending and is taken after the mask clears.
//
// ****************************************************************
// Shared constants and types
// ****************************************************************
package cee_pkg;

   localparam int           IRQ_COUNT       = 12;
   localparam logic [5:0]   VEC_RESET       = 6'h00;
   localparam logic [5:0]   VEC_UNMASKABLE  = 6'h07;
   localparam logic [5:0]   VEC_TRAP_BASE   = 6'h08;
   localparam logic [5:0]   VEC_ADDR_BREAK  = 6'h0c;
   localparam logic [5:0]   VEC_IRQ_BASE    = 6'h0e;
   // Cycles the chip stays in reset after a watchdog overflow
   localparam logic [3:0]   WDT_HOLD_CYCLES = 4'h8;

   typedef enum logic [2:0]
   {
      CEE_RUN  = 3'b001,
      CEE_HOLD = 3'b010,
      CEE_WDT  = 3'b100
   } cee_state_t;

   typedef struct packed
   {
      logic       start;
      logic [5:0] vector;
   } cee_exc_t;

endpackage : cee_pkg

// ****************************************************************
// Edge detector with selectable polarity
// ****************************************************************
`timescale 1ns/10ps
module cee_edge_detect
(
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Sampled level and polarity
   input  wire logic level_in,
   input  wire logic rising_sel,
   // Detected edge
   output      logic edge_pulse
);
   logic prev_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         prev_ff <= 1'b0;
      else
         prev_ff <= level_in;
   end

   // Polarity 0 selects falling, 1 selects rising
   assign edge_pulse = rising_sel ? (level_in & ~prev_ff) : (~level_in & prev_ff); // RULE_09
endmodule : cee_edge_detect

// ==== cee_exception_entry.sv ====
`timescale 1ns/10ps
module cee_exception_entry
(
   // Clock and reset
   input  wire logic       CLK_SYS,
   input  wire logic       RESET_N,
   // Reset sources
   input  wire logic       CHIP_INIT_PIN_N,
   input  wire logic       WDT_OVERFLOW,
   // Sequencer status
   input  wire logic       INSN_BOUNDARY,
   input  wire logic       TRAP_EXEC,
   input  wire logic [1:0] TRAP_SEL,
   input  wire logic       MASK_I,
   // Interrupt sources
   input  wire logic       UNMASKABLE_EDGE_POLARITY,
   input  wire logic       UNMASKABLE_PIN,
   input  wire logic       ADDR_BREAK_REQ,
   input  wire logic [cee_pkg::IRQ_COUNT-1:0] IRQ_REQ,
   // Exception entry
   output      logic       CHIP_RESET,
   output      logic       EXC_START,
   output      logic [5:0] EXC_VECTOR
);
   import cee_pkg::*;

   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_meta_ff;
   logic rst_sync_ff;

   always_ff @(posedge CLK_SYS or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ****************************************************************
   // Fixed priority pick among maskable requests
   // ****************************************************************
   function automatic logic [5:0] irq_vector(input logic [IRQ_COUNT-1:0] req);
      logic [5:0] v;
      v = VEC_IRQ_BASE;
      for (int i = IRQ_COUNT - 1; i >= 0; i--)
      begin
         if (req[i])
            v = VEC_IRQ_BASE + 6'(i);
      end
      return v;
   endfunction : irq_vector

   // ****************************************************************
   // State
   // ****************************************************************
   cee_state_t state_ff;
   cee_state_t nxt_state;
   logic [3:0] wdt_cnt_ff;
   logic       nmi_pend_ff;
   logic       trap_pend_ff;
   logic [1:0] trap_sel_ff;
   logic       reset_ff;
   cee_exc_t   exc_ff;
   cee_exc_t   nxt_exc;
   logic       nmi_edge;
   logic       decide;
   logic       take_nmi;
   logic       take_trap;
   logic       irq_ok;

   cee_edge_detect u_nmi_edge
   (
      .clk        (CLK_SYS),
      .rst_n      (rst_sync_ff),
      .level_in   (UNMASKABLE_PIN),
      .rising_sel (UNMASKABLE_EDGE_POLARITY),
      .edge_pulse (nmi_edge)
   );

   // Trap counts as its own completion point; the unmaskable pin can enter there, other interrupts wait for a boundary
   assign decide = (state_ff == CEE_RUN) && CHIP_INIT_PIN_N && !WDT_OVERFLOW
                   && (INSN_BOUNDARY || TRAP_EXEC); // RULE_07
   // Masked requests are not consumed here, the source keeps them raised
   assign irq_ok = (|IRQ_REQ) && !MASK_I; // RULE_06 RULE_10

   // ****************************************************************
   // Reset sequencing
   // ****************************************************************
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         CEE_RUN:
            if (!CHIP_INIT_PIN_N)
               nxt_state = CEE_HOLD; // RULE_01
            else if (WDT_OVERFLOW)
               nxt_state = CEE_WDT; // RULE_03
         CEE_HOLD:
            if (CHIP_INIT_PIN_N)
               nxt_state = CEE_RUN; // RULE_02
         CEE_WDT:
            if (!CHIP_INIT_PIN_N)
               nxt_state = CEE_HOLD;
            else if (wdt_cnt_ff == WDT_HOLD_CYCLES - 4'h1)
               nxt_state = CEE_RUN;
         default:
            nxt_state = CEE_HOLD;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
         state_ff <= CEE_HOLD;
      else
         state_ff <= nxt_state;
   end

   always_ff @(posedge CLK_SYS or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
         wdt_cnt_ff <= 4'h0;
      else if (state_ff == CEE_WDT)
         wdt_cnt_ff <= wdt_cnt_ff + 4'h1;
      else
         wdt_cnt_ff <= 4'h0;
   end

   always_ff @(posedge CLK_SYS or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
         reset_ff <= 1'b1;
      else
         reset_ff <= (nxt_state != CEE_RUN); // RULE_03
   end

   // ****************************************************************
   // Entry selection
   // ****************************************************************
   always_comb
   begin
      nxt_exc   = '0;
      take_nmi  = 1'b0;
      take_trap = 1'b0;
      if (state_ff != CEE_RUN && nxt_state == CEE_RUN)
      begin
         // Pin release and watchdog expiry enter the same way
         nxt_exc.start  = 1'b1; // RULE_02 RULE_03
         nxt_exc.vector = VEC_RESET;
      end
      else if (decide)
      begin
         // Fixed order: unmaskable, trap, address break, maskable
         if (nmi_pend_ff || nmi_edge)
         begin
            nxt_exc.start  = 1'b1; // RULE_08
            nxt_exc.vector = VEC_UNMASKABLE;
            take_nmi       = 1'b1;
         end
         else if (trap_pend_ff || TRAP_EXEC)
         begin
            nxt_exc.start  = 1'b1; // RULE_04 RULE_05
            nxt_exc.vector = VEC_TRAP_BASE + {4'h0, (TRAP_EXEC ? TRAP_SEL : trap_sel_ff)};
            take_trap      = 1'b1;
         end
         else if (ADDR_BREAK_REQ)
         begin
            nxt_exc.start  = 1'b1;
            nxt_exc.vector = VEC_ADDR_BREAK;
         end
         else if (irq_ok)
         begin
            nxt_exc.start  = 1'b1; // RULE_08
            nxt_exc.vector = irq_vector(IRQ_REQ);
         end
      end
   end

   always_ff @(posedge CLK_SYS or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
         exc_ff <= '0;
      else
         exc_ff <= nxt_exc;
   end

   // ****************************************************************
   // Pending latches
   // ****************************************************************
   // A new edge in the taking cycle survives: set wins over clear
   always_ff @(posedge CLK_SYS or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
         nmi_pend_ff <= 1'b0;
      else if (nxt_state != CEE_RUN || state_ff != CEE_RUN)
         nmi_pend_ff <= 1'b0; // RULE_01
      else
         nmi_pend_ff <= (nmi_pend_ff & ~take_nmi) | (nmi_edge & ~take_nmi) | (nmi_edge & nmi_pend_ff); // RULE_09
   end

   // A trap beaten by the unmaskable pin is kept for the next decision
   always_ff @(posedge CLK_SYS or negedge rst_sync_ff)
   begin
      if (!rst_sync_ff)
      begin
         trap_pend_ff <= 1'b0;
         trap_sel_ff  <= 2'h0;
      end
      else if (nxt_state != CEE_RUN || state_ff != CEE_RUN)
         trap_pend_ff <= 1'b0;
      else if (TRAP_EXEC && !take_trap)
      begin
         trap_pend_ff <= 1'b1; // RULE_05
         trap_sel_ff  <= TRAP_SEL;
      end
      else if (take_trap)
         trap_pend_ff <= 1'b0;
   end

   assign CHIP_RESET = reset_ff;
   assign EXC_START  = exc_ff.start;
   assign EXC_VECTOR = exc_ff.vector;

   // ****************************************************************
   // Checks
   // ****************************************************************
   logic clean_run;
   assign clean_run = (state_ff == CEE_RUN) && CHIP_INIT_PIN_N && !WDT_OVERFLOW;

   property p_reset_wins;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      !CHIP_INIT_PIN_N |=> CHIP_RESET && !EXC_START;
   endproperty
   a_reset_wins: assert property (p_reset_wins) else $error("reset did not win"); // RULE_01

   property p_release_entry;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      (state_ff == CEE_HOLD) && CHIP_INIT_PIN_N |=> EXC_START && (EXC_VECTOR == VEC_RESET) ##1 !CHIP_RESET;
   endproperty
   a_release_entry: assert property (p_release_entry) else $error("no reset entry on release"); // RULE_02

   property p_wdt_entry;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      (state_ff == CEE_RUN) && CHIP_INIT_PIN_N && WDT_OVERFLOW ##1 CHIP_INIT_PIN_N [*8]
      |=> EXC_START && (EXC_VECTOR == VEC_RESET);
   endproperty
   a_wdt_entry: assert property (p_wdt_entry) else $error("watchdog entry wrong"); // RULE_03

   property p_trap_vector;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      TRAP_EXEC && clean_run && !nmi_pend_ff && !nmi_edge && !trap_pend_ff
      |=> EXC_START && (EXC_VECTOR == VEC_TRAP_BASE + {4'h0, $past(TRAP_SEL)});
   endproperty
   a_trap_vector: assert property (p_trap_vector) else $error("trap vector wrong"); // RULE_04

   property p_trap_masked;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      TRAP_EXEC && MASK_I && clean_run && !nmi_pend_ff && !nmi_edge |=> EXC_START;
   endproperty
   a_trap_masked: assert property (p_trap_masked) else $error("trap blocked by mask"); // RULE_05

   property p_mask_blocks;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      EXC_START && (EXC_VECTOR >= VEC_IRQ_BASE) |-> !$past(MASK_I);
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("masked interrupt taken"); // RULE_06

   property p_boundary_only;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      EXC_START && (EXC_VECTOR != VEC_RESET) |-> $past(INSN_BOUNDARY) || $past(TRAP_EXEC);
   endproperty
   a_boundary_only: assert property (p_boundary_only) else $error("entry off boundary"); // RULE_07

   property p_fixed_order;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      EXC_START && (EXC_VECTOR >= VEC_IRQ_BASE)
      |-> !$past(nmi_pend_ff) && !$past(ADDR_BREAK_REQ)
          && (($past(IRQ_REQ) & ((12'h001 << (EXC_VECTOR - VEC_IRQ_BASE)) - 12'h001)) == 12'h000);
   endproperty
   a_fixed_order: assert property (p_fixed_order) else $error("priority order broken"); // RULE_08

   property p_nmi_edge;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      clean_run && !UNMASKABLE_EDGE_POLARITY && $fell(UNMASKABLE_PIN) && !$rose(rst_sync_ff) && CHIP_INIT_PIN_N
      ##1 CHIP_INIT_PIN_N && !WDT_OVERFLOW
      |-> nmi_pend_ff || (EXC_START && EXC_VECTOR == VEC_UNMASKABLE);
   endproperty
   a_nmi_edge: assert property (p_nmi_edge) else $error("unmaskable edge lost"); // RULE_09

   property p_unmask_take;
      @(posedge CLK_SYS) disable iff (!rst_sync_ff)
      clean_run && INSN_BOUNDARY && !MASK_I && (|IRQ_REQ) && !TRAP_EXEC && !trap_pend_ff
      && !nmi_pend_ff && !nmi_edge && !ADDR_BREAK_REQ |=> EXC_START && (EXC_VECTOR >= VEC_IRQ_BASE);
   endproperty
   a_unmask_take: assert property (p_unmask_take) else $error("pending request not taken"); // RULE_10

endmodule : cee_exception_entry

// ==== cee_partner.sv ====
`timescale 1ns/10ps
// ****************************************
// Sequencer and request sources
// ****************************************
module cee_partner
import cee_pkg::*;
(
   // Clock, reset and pacing
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 slow,
   // New requests from the bench
   input  wire logic [IRQ_COUNT-1:0] irq_set,
   input  wire logic                 brk_set,
   // Entry seen from the block
   input  wire logic                 exc_start,
   input  wire logic [5:0]           exc_vector,
   // Sequencer and source outputs
   output      logic                 boundary,
   output      logic                 brk_req,
   output      logic [IRQ_COUNT-1:0] irq_req
);
   logic [2:0]           gap_ff;
   logic [IRQ_COUNT-1:0] served;
   assign served = (exc_start && exc_vector >= VEC_IRQ_BASE) ?
                   IRQ_COUNT'(1) << (exc_vector - VEC_IRQ_BASE) : '0;
   // Sources keep asking until their own vector is entered
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         irq_req <= '0;
         brk_req <= 1'b0;
      end
      else
      begin
         irq_req <= (irq_req | irq_set) & ~served;
         brk_req <= (brk_req | brk_set) & ~(exc_start && exc_vector == VEC_ADDR_BREAK);
      end
   // Handling takes cycles, so no boundary right after an entry
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         gap_ff   <= 3'h0;
         boundary <= 1'b0;
      end
      else
      begin
         boundary <= !exc_start && gap_ff == 3'h0;
         gap_ff   <= exc_start ? 3'h2 : (gap_ff != 3'h0) ? gap_ff - 3'h1 : (slow ? 3'h7 : 3'h1);
      end
endmodule : cee_partner

// ==== tb_top.sv ====
`timescale 1ns/10ps
// ****************************************
// Self-checking bench
// ****************************************
module tb_top;
   import cee_pkg::*;
   logic                 clk_sys = 1'b0;
   logic                 reset_n = 1'b0;
   logic                 init_n = 1'b1;
   logic                 wdt = 1'b0;
   logic                 trap = 1'b0;
   logic [1:0]           sel = 2'h0;
   logic                 mask_i = 1'b1;
   logic                 pol = 1'b0;
   logic                 upin = 1'b1;
   logic                 slow = 1'b0;
   logic                 brk_set = 1'b0;
   logic [IRQ_COUNT-1:0] irq_set = '0;
   logic                 boundary, brk, chip_rst, start;
   logic [IRQ_COUNT-1:0] irq;
   logic [5:0]           vec;
   logic [31:0]          rnd = 32'had760d82;
   int                   fail_count = 0;
   int                   checked = 0;
   int                   cyc = 0;
   int                   cd = 0;
   // Model state: 0 off, 1 run, 2 pin hold, 3 watchdog hold
   int                   m_st = 0;
   int                   m_cnt = 0;
   int                   e_vec = 0;
   logic                 m_prev = 1'b0;
   logic                 m_nmi = 1'b0;
   logic                 m_tp = 1'b0;
   logic [1:0]           m_ts = 2'h0;
   logic                 e_start = 1'b0;
   logic                 e_rst = 1'b0;

   always #5 clk_sys = ~clk_sys;

   cee_exception_entry dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CHIP_INIT_PIN_N(init_n),
      .WDT_OVERFLOW(wdt), .INSN_BOUNDARY(boundary), .TRAP_EXEC(trap), .TRAP_SEL(sel),
      .MASK_I(mask_i), .UNMASKABLE_EDGE_POLARITY(pol), .UNMASKABLE_PIN(upin),
      .ADDR_BREAK_REQ(brk), .IRQ_REQ(irq), .CHIP_RESET(chip_rst), .EXC_START(start),
      .EXC_VECTOR(vec));
   cee_partner far (.clk(clk_sys), .rst_n(reset_n), .slow(slow), .irq_set(irq_set),
      .brk_set(brk_set), .exc_start(start), .exc_vector(vec), .boundary(boundary),
      .brk_req(brk), .irq_req(irq));

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   task automatic check(input logic [5:0] seen, input logic [5:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done;
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done

   // Reference: outputs expected one edge after the deciding edge
   always @(posedge clk_sys)
   begin
      logic nmi_now;
      int   v;
      // An asynchronous reset clears the entry outputs and raises chip reset at once
      if (!reset_n)
      begin
         e_start = 1'b0;
         e_vec = 0;
         e_rst = 1'b1;
      end
      if (m_st != 0)
      begin
         check(6'(start), 6'(e_start));
         check(vec, e_vec[5:0]);
         check(6'(chip_rst), 6'(e_rst));
      end
      nmi_now = pol ? (upin & ~m_prev) : (~upin & m_prev);
      m_prev = reset_n & upin;
      e_start = 1'b0;
      e_vec = 0;
      if (!reset_n)
         m_st = 0;
      if (m_st == 0 && reset_n && chip_rst === 1'b0)
      begin
         e_rst = 1'b0;
         m_st = 1;
      end
      if (m_st == 2 && init_n)
      begin
         // Reset entry and release of the chip reset come together
         e_start = 1'b1;
         e_rst = 1'b0;
         m_st = 1;
      end
      else if (m_st == 3 && !init_n)
         m_st = 2;
      else if (m_st == 3)
      begin
         e_start = m_cnt == 0;
         e_rst = m_cnt != 0;
         m_st = (m_cnt == 0) ? 1 : 3;
         m_cnt--;
      end
      else if (m_st == 1 && (!init_n || wdt))
      begin
         e_rst = 1'b1;
         m_nmi = 1'b0;
         m_tp = 1'b0;
         m_st = init_n ? 3 : 2;
         m_cnt = WDT_HOLD_CYCLES - 1;
      end
      else if (m_st == 1)
      begin
         m_nmi = m_nmi | nmi_now;
         m_tp = m_tp | trap;
         m_ts = trap ? sel : m_ts;
         e_start = boundary | trap;
         if (e_start && m_nmi)
         begin
            e_vec = VEC_UNMASKABLE;
            m_nmi = 1'b0;
         end
         else if (e_start && m_tp)
         begin
            e_vec = VEC_TRAP_BASE + m_ts;
            m_tp = 1'b0;
         end
         else if (e_start && brk)
            e_vec = VEC_ADDR_BREAK;
         else if (e_start && !mask_i && irq != '0)
         begin
            for (v = IRQ_COUNT - 1; v >= 0; v--)
               if (irq[v])
                  e_vec = VEC_IRQ_BASE + v;
         end
         else
            e_start = 1'b0;
      end
   end

   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fail_count++;
         test_done();
      end
   end

   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wait_n

   task automatic fin(input string name);
      $display("test %s done", name);
   endtask : fin

   task automatic power_up;
      logic seen;
      seen = 1'b0;
      reset_n <= 1'b0;
      wait_n(4);
      reset_n <= 1'b1;
      repeat (40)
      begin
         @(posedge clk_sys);
         seen = seen | (start === 1'b1 && vec === VEC_RESET);
         if (chip_rst === 1'b0)
            break;
      end
      check(6'(seen), 6'h01);
      fin("power_up");
   endtask : power_up

   task automatic pulse_trap;
      trap <= 1'b1;
      @(posedge clk_sys);
      trap <= 1'b0;
   endtask : pulse_trap

   initial
   begin
      power_up();
      irq_set <= 12'h808;
      brk_set <= 1'b1;
      @(posedge clk_sys);
      irq_set <= 12'h000;
      brk_set <= 1'b0;
      wait_n(20);
      mask_i <= 1'b0;
      wait_n(40);
      mask_i <= 1'b1;
      fin("masked_pending");
      for (int s = 0; s < 4; s++)
      begin
         sel <= 2'(s);
         pulse_trap();
         wait_n(12);
      end
      fin("trap_selectors");
      // Edge and trap in one cycle: the trap must wait its turn
      upin <= 1'b0;
      pulse_trap();
      wait_n(12);
      pol <= 1'b1;
      wait_n(2);
      upin <= 1'b1;
      wait_n(12);
      fin("unmaskable");
      repeat (3000)
      begin
         @(posedge clk_sys);
         rnd = xs(rnd);
         cd = (cd != 0) ? cd - 1 : 0;
         trap <= cd == 0 && rnd[26:24] == 3'h0 && rnd[27];
         upin <= upin ^ (cd == 0 && rnd[26:24] == 3'h0 && !rnd[27]);
         cd = (cd == 0 && rnd[26:24] == 3'h0) ? 12 : cd;
         sel <= rnd[1:0];
         mask_i <= mask_i ^ (rnd[7:4] == 4'h0);
         slow <= slow ^ (rnd[11:8] == 4'h0);
         pol <= pol ^ (rnd[31:28] == 4'h0 && cd == 0);
         irq_set <= (rnd[13:12] == 2'h0) ? IRQ_COUNT'(1) << (rnd[19:16] % IRQ_COUNT) : '0;
         brk_set <= rnd[23:20] == 4'h0;
      end
      @(posedge clk_sys);
      trap <= 1'b0;
      irq_set <= '0;
      brk_set <= 1'b0;
      mask_i <= 1'b0;
      wait_n(60);
      mask_i <= 1'b1;
      fin("random");
      // Pin reset beats a trap and a masked request in the same cycle
      irq_set <= 12'h010;
      init_n <= 1'b0;
      pulse_trap();
      irq_set <= '0;
      wait_n(4);
      init_n <= 1'b1;
      wait_n(12);
      mask_i <= 1'b0;
      wait_n(20);
      mask_i <= 1'b1;
      fin("pin_reset");
      wdt <= 1'b1;
      pulse_trap();
      wdt <= 1'b0;
      wait_n(20);
      fin("watchdog");
      power_up();
      test_done();
   end
endmodule : tb_top
